// >>> src/split_timer_cfg.svh
// constants for the split auto-reload timer: register addresses, bit positions,
// reset values and prescale counts. assumes inclusion by bare name.
`ifndef SPLIT_TIMER_CFG_SVH
`define SPLIT_TIMER_CFG_SVH

`define ADDR_CONTROL      8'h91
`define ADDR_RELOAD_LOW   8'h92
`define ADDR_RELOAD_HIGH  8'h93
`define ADDR_COUNT_LOW    8'h94
`define ADDR_COUNT_HIGH   8'h95

`define BIT_HIGH_FLAG     7
`define BIT_LOW_FLAG      6
`define BIT_LOW_IE        5
`define BIT_CAPTURE_EN    4
`define BIT_SPLIT         3
`define BIT_RUN           2
`define BIT_UNUSED        1
`define BIT_EXT_CLK       0

`define CONTROL_RESET     8'h00
`define BYTE_RESET        8'h00
`define BYTE_MAX          8'hFF

`define SYS_DIVIDE        12
`define EXT_DIVIDE        8

`endif

// >>> src/split_timer_pkg.sv
// types shared by the split auto-reload timer files.
// assumes the constants header is available for inclusion.
package split_timer_pkg;

  // one register access from the core's special-register port
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // clock choices of one counting byte
  typedef struct packed {
    logic byte_sel;
    logic ext_sel;
  } byte_clock_t;

endpackage

// >>> src/timer_prescaler.sv
// prescaler: system clock / 12 and external clock / 8 as one-cycle enables.
// assumes the external clock is asynchronous and slower than half the system clock.
`timescale 1ns/1ps
`include "split_timer_cfg.svh"
module timer_prescaler import split_timer_pkg::*; #(
  parameter int SYS_DIV = `SYS_DIVIDE,
  parameter int EXT_DIV = `EXT_DIVIDE
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // external clock pin
  input  wire logic ext_clock,
  // enables
  output logic      sys_tick,
  output logic      ext_tick
);
  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);

  logic [SW-1:0] sys_count;
  logic [EW-1:0] ext_count;
  logic          ext_meta;
  logic          ext_sync;
  logic          ext_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_count <= '0;
      sys_tick  <= 1'b0;
    end else if (sys_count == SW'(SYS_DIV - 1)) begin
      sys_count <= '0;
      sys_tick  <= 1'b1;
    end else begin
      sys_count <= sys_count + 1'b1;
      sys_tick  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_clock;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // one tick for every EXT_DIV rising edges of the external clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_count <= '0;
      ext_tick  <= 1'b0;
    end else if (ext_sync && !ext_prev) begin
      ext_count <= (ext_count == EW'(EXT_DIV - 1)) ? '0 : ext_count + 1'b1;
      ext_tick  <= (ext_count == EW'(EXT_DIV - 1));
    end else begin
      ext_tick  <= 1'b0;
    end
  end

endmodule // timer_prescaler

// >>> src/split_auto_reload_timer.sv
// split auto-reload timer: one 16-bit or two 8-bit auto-reload counters,
// overflow flags, interrupt request and low-frequency oscillator capture.
// assumes a single-cycle special-register port from the core on clk; the byte clock
// selects and the timer interrupt enable come from logic on the same clock.
`timescale 1ns/1ps
`include "split_timer_cfg.svh"
module split_auto_reload_timer import split_timer_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // special-register port
  input  wire sfr_req_t   sfr_req,
  output logic [7:0]      sfr_rdata,
  // clock selects held in the clock control register
  input  wire logic       high_byte_clock_select,
  input  wire logic       low_byte_clock_select,
  // external oscillator and low-frequency oscillator pins
  input  wire logic       ext_clock,
  input  wire logic       lfo_out,
  // interrupt controller
  input  wire logic       timer_int_enable,
  output logic            irq_request
);

  logic       high_overflow_flag;
  logic       low_overflow_flag;
  logic       low_interrupt_enable;
  logic       lfo_capture_enable;
  logic       split_mode_select;
  logic       run_control;
  logic       external_clock_select;
  logic [7:0] count_high_byte;
  logic [7:0] count_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] reload_low_byte;

  logic       sys_tick;
  logic       ext_tick;
  logic       lfo_meta;
  logic       lfo_sync;
  logic       lfo_prev;
  logic       capture;
  logic [1:0] byte_tick;
  logic       low_step;
  logic       high_step;
  logic       low_wrap;
  logic       high_wrap;
  logic [7:0] timer_control;

  wire byte_clock_t [1:0] clock_choice = '{
    '{byte_sel: high_byte_clock_select, ext_sel: external_clock_select},
    '{byte_sel: low_byte_clock_select,  ext_sel: external_clock_select}};

  function automatic logic hit(input logic [7:0] a);
    hit = sfr_req.addr == a;
  endfunction

  timer_prescaler #(
    .SYS_DIV (`SYS_DIVIDE),
    .EXT_DIV (`EXT_DIVIDE)
  ) u_prescaler (
    .clk       (clk),
    .rst       (rst),
    .ext_clock (ext_clock),
    .sys_tick  (sys_tick),
    .ext_tick  (ext_tick)
  );

  // per-byte clock selection; index 0 is the low byte, 1 the high byte
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_clk
      assign byte_tick[g] = clock_choice[g].byte_sel ? 1'b1 :
                            (clock_choice[g].ext_sel ? ext_tick : sys_tick);
    end
  endgenerate

  // in 16-bit mode the whole count advances on the low byte's clock
  assign low_step  = split_mode_select ? byte_tick[0] : (run_control && byte_tick[0]);
  assign high_step = split_mode_select ? (run_control && byte_tick[1])
                                       : (low_step && count_low_byte == `BYTE_MAX);
  assign low_wrap  = low_step && count_low_byte == `BYTE_MAX;
  assign high_wrap = high_step && count_high_byte == `BYTE_MAX;

  // low-frequency oscillator is asynchronous: two flops before the edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfo_meta <= 1'b0;
      lfo_sync <= 1'b0;
      lfo_prev <= 1'b0;
    end else begin
      lfo_meta <= lfo_out;
      lfo_sync <= lfo_meta;
      lfo_prev <= lfo_sync;
    end
  end

  assign capture = lfo_capture_enable && timer_int_enable && lfo_sync && !lfo_prev;

  // control bits written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_interrupt_enable  <= 1'b0;
      lfo_capture_enable    <= 1'b0;
      split_mode_select     <= 1'b0;
      run_control           <= 1'b0;
      external_clock_select <= 1'b0;
    end else if (sfr_req.wr && hit(`ADDR_CONTROL)) begin
      low_interrupt_enable  <= sfr_req.wdata[`BIT_LOW_IE];
      lfo_capture_enable    <= sfr_req.wdata[`BIT_CAPTURE_EN];
      split_mode_select     <= sfr_req.wdata[`BIT_SPLIT];
      run_control           <= sfr_req.wdata[`BIT_RUN];
      external_clock_select <= sfr_req.wdata[`BIT_EXT_CLK];
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag  <= 1'b0;
    end else begin
      if (high_wrap)
        high_overflow_flag <= 1'b1;
      else if (sfr_req.wr && hit(`ADDR_CONTROL))
        high_overflow_flag <= sfr_req.wdata[`BIT_HIGH_FLAG];
      if (low_wrap)
        low_overflow_flag <= 1'b1;
      else if (sfr_req.wr && hit(`ADDR_CONTROL))
        low_overflow_flag <= sfr_req.wdata[`BIT_LOW_FLAG];
    end
  end

  // counting bytes; a software write to a count byte wins over counting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_low_byte <= `BYTE_RESET;
    end else if (sfr_req.wr && hit(`ADDR_COUNT_LOW)) begin
      count_low_byte <= sfr_req.wdata;
    end else if (low_wrap) begin
      // 16-bit mode reloads only when the high byte also wraps
      if (split_mode_select || count_high_byte == `BYTE_MAX)
        count_low_byte <= reload_low_byte;
      else
        count_low_byte <= 8'h00;
    end else if (low_step) begin
      count_low_byte <= count_low_byte + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_high_byte <= `BYTE_RESET;
    end else if (sfr_req.wr && hit(`ADDR_COUNT_HIGH)) begin
      count_high_byte <= sfr_req.wdata;
    end else if (high_wrap) begin
      count_high_byte <= reload_high_byte;
    end else if (high_step) begin
      count_high_byte <= count_high_byte + 8'h01;
    end
  end

  // reload bytes; a capture overrides a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_low_byte  <= `BYTE_RESET;
      reload_high_byte <= `BYTE_RESET;
    end else if (capture) begin
      reload_low_byte  <= count_low_byte;
      reload_high_byte <= count_high_byte;
    end else if (sfr_req.wr) begin
      if (hit(`ADDR_RELOAD_LOW))
        reload_low_byte <= sfr_req.wdata;
      if (hit(`ADDR_RELOAD_HIGH))
        reload_high_byte <= sfr_req.wdata;
    end
  end

  // interrupt request: level while a qualifying flag stands, plus the capture pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq_request <= 1'b0;
    else
      irq_request <= timer_int_enable &&
                     (high_overflow_flag
                      || (low_interrupt_enable && low_overflow_flag)
                      || capture);
  end

  always_comb begin
    timer_control              = `CONTROL_RESET;
    timer_control[`BIT_HIGH_FLAG]  = high_overflow_flag;
    timer_control[`BIT_LOW_FLAG]   = low_overflow_flag;
    timer_control[`BIT_LOW_IE]     = low_interrupt_enable;
    timer_control[`BIT_CAPTURE_EN] = lfo_capture_enable;
    timer_control[`BIT_SPLIT]      = split_mode_select;
    timer_control[`BIT_RUN]        = run_control;
    timer_control[`BIT_UNUSED]     = 1'b0;
    timer_control[`BIT_EXT_CLK]    = external_clock_select;
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        `ADDR_CONTROL:     sfr_rdata <= timer_control;
        `ADDR_RELOAD_LOW:  sfr_rdata <= reload_low_byte;
        `ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_byte;
        `ADDR_COUNT_LOW:   sfr_rdata <= count_low_byte;
        `ADDR_COUNT_HIGH:  sfr_rdata <= count_high_byte;
        default:           sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule // split_auto_reload_timer

// >>> test/split_timer_asserts.sv
// checker for the split timer, sees the top ports only.
// assumes wr and rd are never high in one cycle.
`timescale 1ns/1ps
module split_timer_asserts import split_timer_pkg::*; (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire sfr_req_t   sfr_req,
  input wire logic [7:0] sfr_rdata,
  // pins
  input wire logic       low_byte_clock_select,
  input wire logic       lfo_out,
  input wire logic       timer_int_enable,
  input wire logic       irq_request
);
  logic [7:0] shadow;
  logic       rd_ctl;
  logic       mapped;
  assign rd_ctl = sfr_req.rd && sfr_req.addr == 8'h91;
  assign mapped = sfr_req.addr >= 8'h91 && sfr_req.addr <= 8'h95;
  // software-owned bits only; flags move by themselves
  always_ff @(posedge clk or posedge rst)
    if (rst) shadow <= 8'h00;
    else if (sfr_req.wr && sfr_req.addr == 8'h91) shadow <= sfr_req.wdata & 8'h3D;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_bit1; rd_ctl |=> !sfr_rdata[1]; endproperty
  a_bit1: assert property (p_bit1) else $error("bit 1 read as one");
  property p_unmapped; sfr_req.rd && !mapped |=> sfr_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !sfr_req.rd |=> $stable(sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_irq_en; irq_request |-> $past(timer_int_enable); endproperty
  a_irq_en: assert property (p_irq_en) else $error("request without enable");
  property p_ctl; rd_ctl |=> sfr_rdata[5:0] == shadow[5:0]; endproperty
  a_ctl: assert property (p_ctl) else $error("control bits lost");
  property p_sticky;
    rd_ctl ##1 rd_ctl |=> ($past(sfr_rdata) & sfr_rdata & 8'hC0) == ($past(sfr_rdata) & 8'hC0);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by itself");
  property p_capture;
    $rose(lfo_out) && shadow[4] && timer_int_enable |-> ##[2:6] (irq_request || !timer_int_enable || !shadow[4]);
  endproperty
  a_capture: assert property (p_capture) else $error("no capture request");
  property p_low_irq;
    shadow[5] && shadow[3] && low_byte_clock_select && timer_int_enable
      |-> ##[0:260] (irq_request || sfr_req.wr || !timer_int_enable || !low_byte_clock_select);
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("no low overflow request");
  c_capture: cover property ($rose(lfo_out) && shadow[4] ##[2:6] irq_request);
  c_low_irq: cover property (shadow[5] && irq_request);
  c_sticky: cover property (rd_ctl ##1 rd_ctl ##1 sfr_rdata[7]);
endmodule // split_timer_asserts

// >>> test/split_auto_reload_timer_test.sv
// bench for the split timer; inputs other than ext_clock move at the falling edge.
// assumes the checker module is compiled first.
`timescale 1ns/1ps
module split_auto_reload_timer_test;
  import split_timer_pkg::*;
  logic        clk, rst, hsel, lsel, ext_clock, lfo_out, int_en, irq, seen;
  sfr_req_t    req;
  logic [7:0]  rdata, v;
  logic [31:0] lfsr = 32'h6B69B636;
  int          n_fail = 0;
  int          total_checks = 0;
  split_auto_reload_timer dut (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .high_byte_clock_select(hsel), .low_byte_clock_select(lsel), .ext_clock(ext_clock),
    .lfo_out(lfo_out), .timer_int_enable(int_en), .irq_request(irq));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bit 1 never stored
  function automatic logic [7:0] ctl_expect(input logic [7:0] d);
    return d & 8'hFD;
  endfunction
  task automatic chk8(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.rd = 1'b1;
    repeat (n) @(negedge clk);
    req.rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    rst = 1;
    req = '0;
    {hsel, lsel, ext_clock, lfo_out, int_en} = 5'h00;
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 0;
    for (int a = 8'h90; a <= 8'h95; a++) begin
      wr(8'h90, 8'hAB);
      rd(a[7:0], 1, v);
      chk8("reset value", 8'h00, v);
    end
    $display("reset test done");
    repeat (8) begin
      lfsr = step(lfsr);
      wr(8'h91, lfsr[7:0] & 8'hF3);
      rd(8'h91, 1, v);
      chk8("control", ctl_expect(lfsr[7:0] & 8'hF3), v);
      chk1("irq off", 1'b0, irq);
    end
    $display("control test done");
    wr(8'h91, 8'h00);
    wr(8'h92, 8'hF0);
    wr(8'h94, 8'hFF);
    lsel = 1;
    int_en = 1;
    wr(8'h91, 8'h28);
    repeat (4) @(negedge clk);
    chk1("low irq", 1'b1, irq);
    rd(8'h91, 2, v);
    chk8("low flag", 8'h68, v);
    rd(8'h95, 1, v);
    chk8("high idle", 8'h00, v);
    rd(8'h94, 1, v);
    chk1("low reload", 1'b1, v >= 8'hF0);
    wr(8'h91, 8'h08);
    repeat (3) @(negedge clk);
    chk1("masked irq", 1'b0, irq);
    wr(8'h91, 8'h28);
    int_en = 0;
    repeat (3) @(negedge clk);
    chk1("no enable", 1'b0, irq);
    $display("split low test done");
    lsel = 0;
    int_en = 1;
    wr(8'h91, 8'h08);
    wr(8'h93, 8'hFE);
    wr(8'h95, 8'hFF);
    wr(8'h91, 8'h0C);
    repeat (30) @(negedge clk);
    chk1("high irq", 1'b1, irq);
    rd(8'h91, 1, v);
    chk8("high flag", 8'h8C, v & 8'hBF);
    rd(8'h95, 1, v);
    chk1("high reload", 1'b1, v >= 8'hFE);
    $display("split high test done");
    {hsel, lsel} = 2'h3;
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h00);
    wr(8'h93, 8'hFF);
    wr(8'h94, 8'hFE);
    wr(8'h95, 8'hFF);
    wr(8'h91, 8'h04);
    repeat (4) @(negedge clk);
    rd(8'h91, 1, v);
    chk8("wide flags", 8'hC4, v);
    rd(8'h95, 1, v);
    chk8("wide reload", 8'hFF, v);
    $display("wide test done");
    lsel = 0;
    // any 120 consecutive edges hold exactly ten divide-by-12 ticks, whatever the phase
    wr(8'h91, 8'h08);
    wr(8'h94, 8'h00);
    repeat (119) @(negedge clk);
    rd(8'h94, 1, v);
    chk8("divided count", 8'h0A, v);
    wr(8'h91, 8'h09);
    wr(8'h92, 8'h00);
    wr(8'h94, 8'h00);
    repeat (40) @(negedge clk);
    rd(8'h94, 1, v);
    chk8("ext idle", 8'h00, v);
    repeat (16) begin
      #23 ext_clock = 1;
      #17 ext_clock = 0;
    end
    repeat (6) @(negedge clk);
    rd(8'h94, 1, v);
    chk8("ext count", 8'h02, v);
    $display("external clock test done");
    wr(8'h91, 8'h10);
    lfsr = step(lfsr);
    wr(8'h94, lfsr[7:0]);
    wr(8'h95, lfsr[15:8]);
    lfo_out = 1;
    seen = 0;
    repeat (8) begin
      @(negedge clk);
      seen |= irq;
    end
    chk1("capture irq", 1'b1, seen);
    rd(8'h92, 1, v);
    chk8("capture low", lfsr[7:0], v);
    rd(8'h93, 1, v);
    chk8("capture high", lfsr[15:8], v);
    $display("capture test done");
    end_of_test();
  end
endmodule // split_auto_reload_timer_test

bind split_auto_reload_timer split_timer_asserts chk (.clk(clk), .rst(rst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .low_byte_clock_select(low_byte_clock_select), .lfo_out(lfo_out),
  .timer_int_enable(timer_int_enable), .irq_request(irq_request));
